// ===== src/acs_regs.svh
// Constants of the conversion sequencer: dividers, conversion lengths and serial timeout.
// Assumes a 25 MHz system clock; included by its bare name wherever a figure is needed.
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

`define ACS_CLK_FREQ_HZ       25000000
`define ACS_OSC_FREQ_HZ       1000000
`define ACS_OSC_DIV           (`ACS_CLK_FREQ_HZ / `ACS_OSC_FREQ_HZ)
`define ACS_MOD_DIV           4
`define ACS_CODE_WIDTH        16
`define ACS_CODE_MSB          15
`define ACS_SEL_SINGLE_BIT    2
`define ACS_RST_SEL           3'h0
`define ACS_RST_POS_IN        2'h0
`define ACS_RST_NEG_IN        2'h1
`define ACS_RST_RESULT        16'h0000

`define ACS_CONV_TICKS_DR0    15'h7A12
`define ACS_CONV_TICKS_DR1    15'h3D09
`define ACS_CONV_TICKS_DR2    15'h1E84
`define ACS_CONV_TICKS_DR3    15'h0F42
`define ACS_CONV_TICKS_DR4    15'h07A1
`define ACS_CONV_TICKS_DR5    15'h03E8
`define ACS_CONV_TICKS_DR6    15'h020E
`define ACS_CONV_TICKS_DR7    15'h0122

`define ACS_SCLK_TIMEOUT_US   30800
`define ACS_SCLK_TIMEOUT_CYC  (`ACS_SCLK_TIMEOUT_US * (`ACS_CLK_FREQ_HZ / 1000000))

`endif

// ===== src/acs_pkg.sv
// Types shared by the conversion sequencer and its serial output stage.
// Assumes the constants header is on the include path.
`include "acs_regs.svh"

package acs_pkg;

  typedef logic [`ACS_CODE_WIDTH-1:0] acs_code_type;
  typedef logic [2:0]                 acs_sel_type;
  typedef logic [1:0]                 acs_input_type;

  typedef enum logic [0:0] {
    ACS_ST_POWER_DOWN = 1'b0,
    ACS_ST_CONVERT    = 1'b1
  } acs_seq_state_type;

  typedef struct packed {
    acs_seq_state_type state;
    logic              converting;
    logic              powered_down;
    logic [4:0]        osc_cnt;
    logic [1:0]        mod_phase;
    logic              mod_clk;
    logic [14:0]       conv_cnt;
    logic [14:0]       conv_len;
    acs_sel_type       sel;
    acs_input_type     pos_in;
    acs_input_type     neg_in;
    logic              neg_gnd;
    acs_code_type      result;
    logic              done;
  } acs_seq_type;

  typedef struct packed {
    logic [2:0]   cs_sync;
    logic [2:0]   sclk_sync;
    logic         cs_n;
    logic         sclk;
    acs_code_type shift;
    logic         first;
    logic [19:0]  low_cnt;
    logic         dout;
    logic         dout_oe;
  } acs_spi_type;

endpackage : acs_pkg

// ===== src/acs_result_if.sv
// Carries the latest conversion result from the sequencer to the serial output stage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface acs_result_if;
  import acs_pkg::*;

  acs_code_type word;

  modport producer (output word);
  modport consumer (input word);

endinterface : acs_result_if

`default_nettype wire

// ===== src/acs_spi_out.sv
// Serial output stage: shifts the latest result out under chip-select and serial clock.
// Assumes chip-select and serial clock are asynchronous pins, synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

module acs_spi_out #(
  parameter int TIMEOUT_CYCLES = `ACS_SCLK_TIMEOUT_CYC
) (
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  acs_result_if.consumer result,
  input  wire logic      i_cs_n,
  input  wire logic      i_sclk,
  output logic           o_dout,
  output logic           o_dout_oe
);
  import acs_pkg::*;

  acs_spi_type r;
  acs_spi_type next_r;
  logic        sclk_rise;
  logic        cs_fall;
  logic        timeout;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    next_r = r;
    next_r.cs_sync   = {r.cs_sync[1:0], i_cs_n};
    next_r.sclk_sync = {r.sclk_sync[1:0], i_sclk};
    if (r.cs_sync[1] == r.cs_sync[2]) begin
      next_r.cs_n = r.cs_sync[2];
    end
    if (r.sclk_sync[1] == r.sclk_sync[2]) begin
      next_r.sclk = r.sclk_sync[2];
    end
    sclk_rise = !r.sclk && next_r.sclk;
    cs_fall   = r.cs_n && !next_r.cs_n;
    timeout   = 1'b0;
    if (next_r.sclk) begin
      next_r.low_cnt = 20'h00000;
    end else if (r.low_cnt != 20'(TIMEOUT_CYCLES)) begin
      next_r.low_cnt = r.low_cnt + 20'h00001;
      timeout        = (next_r.low_cnt == 20'(TIMEOUT_CYCLES));
    end
    if (cs_fall || timeout) begin
      next_r.shift = result.word;
      next_r.first = 1'b1;
    end else if (sclk_rise && !next_r.cs_n) begin
      if (r.first) begin
        next_r.first = 1'b0;
      end else begin
        next_r.shift = {r.shift[`ACS_CODE_MSB-1:0], 1'b0};
      end
    end
    next_r.dout    = next_r.shift[`ACS_CODE_MSB];
    next_r.dout_oe = !next_r.cs_n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '{cs_sync: 3'h7, sclk_sync: 3'h0, cs_n: 1'b1, sclk: 1'b0,
             shift: 16'h0000, first: 1'b1, low_cnt: 20'h00000,
             dout: 1'b0, dout_oe: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign o_dout    = r.dout;
  assign o_dout_oe = r.dout_oe;

endmodule : acs_spi_out

`default_nettype wire

// ===== src/acs_top.sv
// Conversion sequencer: clock division, conversion timing, input routing, result store.
// Assumes an external converter core whose filter output is steady when a conversion ends.
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"

module acs_top #(
  parameter int SCLK_TIMEOUT_CYCLES = `ACS_SCLK_TIMEOUT_CYC
) (
  input  wire logic            i_clk,
  input  wire logic            i_resetn,
  input  wire logic            i_start,
  input  wire logic            i_continuous,
  input  wire acs_pkg::acs_sel_type  i_input_select,
  input  wire logic [2:0]      i_data_rate,
  input  wire acs_pkg::acs_code_type i_filter_code,
  input  wire logic            i_cs_n,
  input  wire logic            i_sclk,
  output logic                 o_mod_clk,
  output logic                 o_converting,
  output logic                 o_powered_down,
  output acs_pkg::acs_input_type     o_positive_input_sel,
  output acs_pkg::acs_input_type     o_negative_input_sel,
  output logic                 o_negative_to_ground,
  output acs_pkg::acs_code_type      o_result,
  output logic                 o_result_done,
  output logic                 o_dout,
  output logic                 o_dout_oe
);
  import acs_pkg::*;

  logic [1:0]    rst_sync;
  logic          rst_n;
  acs_seq_type   r;
  acs_seq_type   next_r;
  logic          osc_tick;
  logic          mod_tick;
  logic          finish;
  logic          begin_conv;
  logic [14:0]   rate_len;
  acs_code_type  code;
  acs_input_type route_pos;
  acs_input_type route_neg;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset value of the sequencer state.
  localparam acs_seq_type SEQ_RESET = '{
    state:        ACS_ST_POWER_DOWN,
    converting:   1'b0,
    powered_down: 1'b1,
    osc_cnt:      5'h00,
    mod_phase:    2'h0,
    mod_clk:      1'b0,
    conv_cnt:     15'h0000,
    conv_len:     15'h0000,
    sel:          `ACS_RST_SEL,
    pos_in:       `ACS_RST_POS_IN,
    neg_in:       `ACS_RST_NEG_IN,
    neg_gnd:      1'b0,
    result:       `ACS_RST_RESULT,
    done:         1'b0
  };

  acs_result_if  result_link ();

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion length in modulator periods for each data rate code.
  always_comb begin
    case (i_data_rate)
      3'h0:    rate_len = `ACS_CONV_TICKS_DR0;
      3'h1:    rate_len = `ACS_CONV_TICKS_DR1;
      3'h2:    rate_len = `ACS_CONV_TICKS_DR2;
      3'h3:    rate_len = `ACS_CONV_TICKS_DR3;
      3'h4:    rate_len = `ACS_CONV_TICKS_DR4;
      3'h5:    rate_len = `ACS_CONV_TICKS_DR5;
      3'h6:    rate_len = `ACS_CONV_TICKS_DR6;
      default: rate_len = `ACS_CONV_TICKS_DR7;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input routing for each select code.
  always_comb begin
    case (i_input_select)
      3'h0: begin
        route_pos = 2'h0;
        route_neg = 2'h1;
      end
      3'h1: begin
        route_pos = 2'h0;
        route_neg = 2'h3;
      end
      3'h2: begin
        route_pos = 2'h1;
        route_neg = 2'h3;
      end
      3'h3: begin
        route_pos = 2'h2;
        route_neg = 2'h3;
      end
      default: begin
        route_pos = i_input_select[1:0];
        route_neg = 2'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the sequencer.
  always_comb begin
    next_r     = r;
    next_r.done = 1'b0;
    finish     = 1'b0;
    begin_conv = 1'b0;
    code       = i_filter_code;

    // Oscillator and modulator clock dividers run at all times.
    osc_tick = (r.osc_cnt == 5'(`ACS_OSC_DIV - 1));
    if (osc_tick) begin
      next_r.osc_cnt   = 5'h00;
      next_r.mod_phase = r.mod_phase + 2'h1;
    end else begin
      next_r.osc_cnt = r.osc_cnt + 5'h01;
    end
    mod_tick       = osc_tick && (r.mod_phase == 2'(`ACS_MOD_DIV - 1));
    next_r.mod_clk = next_r.mod_phase[1];

    case (r.state)
      ACS_ST_POWER_DOWN: begin
        begin_conv = i_start || i_continuous;
      end
      ACS_ST_CONVERT: begin
        if (mod_tick) begin
          if (r.conv_cnt == r.conv_len - 15'h0001) begin
            finish = 1'b1;
          end else begin
            next_r.conv_cnt = r.conv_cnt + 15'h0001;
          end
        end
      end
      default: begin
        next_r.state = ACS_ST_POWER_DOWN;
      end
    endcase

    if (finish) begin
      if (r.sel[`ACS_SEL_SINGLE_BIT] && code[`ACS_CODE_MSB]) begin
        code = '0;
      end
      next_r.result = code;
      next_r.done   = 1'b1;
      if (i_continuous) begin
        begin_conv = 1'b1;
      end else begin
        next_r.state = ACS_ST_POWER_DOWN;
      end
    end

    if (begin_conv) begin
      next_r.state    = ACS_ST_CONVERT;
      next_r.conv_cnt = 15'h0000;
      next_r.conv_len = rate_len;
      next_r.sel      = i_input_select;
      next_r.pos_in   = route_pos;
      next_r.neg_in   = route_neg;
      next_r.neg_gnd = i_input_select[`ACS_SEL_SINGLE_BIT];
    end

    // Status flags follow the next state so that both outputs come from flip-flops.
    next_r.converting   = (next_r.state == ACS_ST_CONVERT);
    next_r.powered_down = (next_r.state == ACS_ST_POWER_DOWN);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= SEQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial output stage.
  assign result_link.word = r.result;

  acs_spi_out #(
    .TIMEOUT_CYCLES (SCLK_TIMEOUT_CYCLES)
  ) u_spi_out (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .result    (result_link.consumer),
    .i_cs_n    (i_cs_n),
    .i_sclk    (i_sclk),
    .o_dout    (o_dout),
    .o_dout_oe (o_dout_oe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each from a flip-flop.
  assign o_mod_clk            = r.mod_clk;
  assign o_converting         = r.converting;
  assign o_powered_down       = r.powered_down;
  assign o_positive_input_sel = r.pos_in;
  assign o_negative_input_sel = r.neg_in;
  assign o_negative_to_ground = r.neg_gnd;
  assign o_result             = r.result;
  assign o_result_done        = r.done;

endmodule : acs_top

`default_nettype wire

// ===== bench/acs_host_model.sv
// Serial host model: frames a result read with chip-select and serial clock pulses.
// Assumes the data pin it samples is already resolved to a level.
`timescale 1ns/1ps
`default_nettype none

module acs_host_model (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_cs_n,
  output logic      o_sclk
);
  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h0;
  end

  // Clock stands low outside frames; each bit is taken late in the low phase.
  task automatic read(input int n, output logic [15:0] w);
    w = 16'h0000;
    @(posedge i_clk) o_cs_n <= 1'h0;
    repeat (8) @(posedge i_clk);
    for (int b = 0; b < n; b++) begin
      o_sclk <= 1'h1;
      repeat (6) @(posedge i_clk);
      o_sclk <= 1'h0;
      repeat (6) @(posedge i_clk);
      w = {w[14:0], i_miso};
    end
  endtask : read

  task automatic release_cs;
    @(posedge i_clk) o_cs_n <= 1'h1;
    repeat (8) @(posedge i_clk);
  endtask : release_cs
endmodule : acs_host_model

`default_nettype wire

// ===== bench/acs_top_chk.sv
// Assertion checker for the conversion sequencer top.
// Assumes it is bound to acs_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module acs_top_chk (
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  input wire logic                   i_start,
  input wire logic                   i_continuous,
  input wire acs_pkg::acs_sel_type   i_input_select,
  input wire logic                   i_cs_n,
  input wire logic                   i_sclk,
  input wire logic                   o_mod_clk,
  input wire logic                   o_converting,
  input wire logic                   o_powered_down,
  input wire acs_pkg::acs_input_type o_positive_input_sel,
  input wire logic                   o_negative_to_ground,
  input wire acs_pkg::acs_code_type  o_result,
  input wire logic                   o_result_done,
  input wire logic                   o_dout,
  input wire logic                   o_dout_oe
);
  import acs_pkg::*;
  logic [7:0] low_cnt;

  // Counts serial clock low cycles inside a selected frame.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= (i_sclk || i_cs_n) ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_start_taken: assert property (o_powered_down && i_start |=> o_converting)
    else $error("start request not taken");
  chk_single_sleep: assert property (o_result_done && !$past(i_continuous) |-> o_powered_down && !o_converting)
    else $error("no power-down after single conversion");
  chk_cont_chain: assert property (o_result_done && $past(i_continuous) |-> o_converting)
    else $error("continuous conversion did not restart");
  chk_result_hold: assert property (!o_result_done |-> $stable(o_result))
    else $error("result changed without completion");
  chk_se_nonneg: assert property (o_result_done && o_negative_to_ground |-> !o_result[15])
    else $error("negative single-ended result");
  chk_se_route: assert property ($rose(o_converting) |-> o_negative_to_ground == $past(i_input_select[2]) && (!o_negative_to_ground || o_positive_input_sel == $past(i_input_select[1:0])))
    else $error("single-ended routing wrong");
  chk_oe_release: assert property (i_cs_n [*6] |-> !o_dout_oe)
    else $error("data driven without chip-select");
  chk_dout_steady: assert property (low_cnt >= 8'h08 && low_cnt <= 8'h28 |-> $stable(o_dout))
    else $error("data changed while serial clock low");
  chk_mod_rate: assert property ($changed(o_mod_clk) |-> ##50 $changed(o_mod_clk))
    else $error("modulator clock half period wrong");

  cover property (o_result_done && o_negative_to_ground);
  cover property (o_result_done && o_converting);
  cover property ($fell(o_dout_oe));
endmodule : acs_top_chk

bind acs_top acs_top_chk chk_i (.i_clk, .i_resetn, .i_start, .i_continuous, .i_input_select,
  .i_cs_n, .i_sclk, .o_mod_clk, .o_converting, .o_powered_down, .o_positive_input_sel,
  .o_negative_to_ground, .o_result, .o_result_done, .o_dout, .o_dout_oe);

`default_nettype wire

// ===== bench/acs_top_tb.sv
// Bench for the conversion sequencer: single-shot, continuous and serial reads.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module acs_top_tb;
  import acs_pkg::*;
  logic          i_clk, i_resetn, i_start, i_continuous, i_cs_n, i_sclk;
  logic          o_mod_clk, o_converting, o_powered_down, o_negative_to_ground;
  logic          o_result_done, o_dout, o_dout_oe;
  logic [2:0]    i_data_rate;
  acs_sel_type   i_input_select, sel1;
  acs_input_type o_positive_input_sel, o_negative_input_sel;
  acs_code_type  i_filter_code, o_result, w, code1, code2;
  int            n_errors, checked, seed, cyc, t1;
  // A released data line falls to its pull-down level.
  wire logic miso = o_dout_oe ? o_dout : 1'h0;
  wire logic [4:0] rt = {o_negative_to_ground, o_positive_input_sel,
                         o_negative_to_ground ? 2'h0 : o_negative_input_sel};

  acs_top #(.SCLK_TIMEOUT_CYCLES(50)) acs_top_i (.i_clk, .i_resetn, .i_start, .i_continuous,
    .i_input_select, .i_data_rate, .i_filter_code, .i_cs_n, .i_sclk, .o_mod_clk, .o_converting,
    .o_powered_down, .o_positive_input_sel, .o_negative_input_sel, .o_negative_to_ground,
    .o_result, .o_result_done, .o_dout, .o_dout_oe);
  acs_host_model host_i (.i_clk, .i_miso(miso), .o_cs_n(i_cs_n), .o_sclk(i_sclk));

  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc++;

  function automatic acs_code_type exp_code(acs_sel_type s, acs_code_type c);
    return (s[2] && c[15]) ? 16'h0000 : c;
  endfunction : exp_code

  function automatic logic [4:0] exp_route(acs_sel_type s);
    if (s[2]) return {1'h1, s[1:0], 2'h0};
    return {1'h0, (s == 3'h0) ? 2'h0 : 2'(s - 3'h1), (s == 3'h0) ? 2'h1 : 2'h3};
  endfunction : exp_route

  task automatic chk(string nm, acs_code_type e, acs_code_type g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_result_done !== 1'h1 && n < 29200);
    if (n >= 29200) chk("done wait", 16'h0001, 16'h0000);
  endtask : wait_done

  task automatic stop_test;
    $display("errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (98000) @(posedge i_clk);
    n_errors++;
    stop_test;
  end

  initial begin
    seed = 18;
    i_resetn = 1'h0;
    i_start = 1'h0;
    i_continuous = 1'h0;
    i_input_select = 3'h0;
    i_data_rate = 3'h7;
    i_filter_code = 16'h0000;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'h1;
    repeat (4) @(posedge i_clk);
    // Single-shot on a single-ended input with a negative code; a second request is ignored.
    i_input_select <= 3'h4 | 3'($random(seed) & 3);
    i_filter_code <= 16'h8000 | 16'($random(seed));
    i_start <= 1'h1;
    @(posedge i_clk) i_start <= 1'h0;
    repeat (100) @(posedge i_clk);
    i_start <= 1'h1;
    @(posedge i_clk) i_start <= 1'h0;
    wait_done;
    chk("result", exp_code(i_input_select, i_filter_code), o_result);
    chk("route", 16'(exp_route(i_input_select)), 16'(rt));
    chk("sleep", 16'h0003, 16'({o_powered_down, !o_converting}));
    repeat (300) @(negedge i_clk);
    chk("one run", 16'h0001, 16'(o_powered_down));
    host_i.read(16, w);
    host_i.release_cs;
    chk("serial", exp_code(i_input_select, i_filter_code), w);
    chk("released", 16'h0000, 16'(o_dout_oe));
    // Continuous on a pair; filter code and mode changed mid-run apply from the next completion, while the routing keeps the old input select.
    sel1 = 3'($random(seed) & 3);
    code1 = 16'($random(seed));
    i_input_select <= sel1;
    i_filter_code <= code1;
    i_continuous <= 1'h1;
    wait_done;
    t1 = cyc;
    chk("result", code1, o_result);
    chk("route", 16'(exp_route(sel1)), 16'(rt));
    chk("chain", 16'h0001, 16'(o_converting));
    code2 = 16'($random(seed));
    @(posedge i_clk) i_filter_code <= code2;
    i_input_select <= 3'h4;
    i_continuous <= 1'h0;
    host_i.read(8, w);
    repeat (60) @(posedge i_clk);
    host_i.read(16, w);
    host_i.release_cs;
    chk("latest", code1, w);
    wait_done;
    chk("rate gap", 16'h0001, 16'(cyc - t1 >= 29000 && cyc - t1 <= 29100));
    chk("result", code2, o_result);
    chk("route hold", 16'(exp_route(sel1)), 16'(rt));
    chk("mode off", 16'h0001, 16'(o_powered_down));
    // A reset in mid-conversion at another rate returns every output to its idle level.
    @(posedge i_clk) i_data_rate <= 3'({$random(seed)} % 7);
    i_start <= 1'h1;
    @(posedge i_clk) i_start <= 1'h0;
    repeat (300) @(posedge i_clk);
    i_resetn <= 1'h0;
    repeat (6) @(posedge i_clk);
    chk("reset", 16'h0004, 16'({o_powered_down, o_converting, o_dout_oe}));
    chk("reset clk", 16'h0000, 16'({o_result_done, o_mod_clk}));
    chk("reset route", 16'h0001, 16'(rt));
    chk("reset result", 16'h0000, o_result);
    i_resetn <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_start <= 1'h1;
    @(posedge i_clk) i_start <= 1'h0;
    @(negedge i_clk);
    chk("restart", 16'h0001, 16'(o_converting));
    stop_test;
  end
endmodule : acs_top_tb

`default_nettype wire
